/* chm_pkg.sv */
/*
 * Constants for the per-channel serial control and monitor port:
 * frame and bit timing, control word layout, input indices and the
 * codes of the flexible control and flexible monitor selections.
 * Assumes a single 20 MHz system clock and a 32 channel, 125 us frame.
 */

//******************************************************************
//******************************************************************

package chm_pkg;

   //******************************************************************
   // Timing
   //******************************************************************
   localparam int CLK_KHZ        = 20000;
   localparam int BIT_RATE_KBPS  = 256;
   localparam int FRAME_US       = 125;
   localparam int NUM_CH         = 32;
   localparam int CH_W           = 5;
   localparam int SYNC_PULSE_NS  = 488;
   // Longest pulse rounds down to whole cycles, never below one
   localparam int SYNC_PULSE_RAW = (SYNC_PULSE_NS * CLK_KHZ) / 1000000;
   localparam int SYNC_PULSE_CYC = (SYNC_PULSE_RAW < 1) ? 1 : SYNC_PULSE_RAW;
   localparam int SYNC_CNT_W     = 4;
   // Fractional bit-rate accumulator: step per clock, modulus per bit
   localparam int ACC_W          = 16;
   localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(BIT_RATE_KBPS);
   localparam logic [ACC_W-1:0] ACC_MOD  = ACC_W'(CLK_KHZ);
   localparam logic [ACC_W-1:0] ACC_HALF = ACC_W'(CLK_KHZ / 2);

   //******************************************************************
   // Control inputs and their mask bits
   //******************************************************************
   localparam int NUM_CTL  = 6;
   localparam int IN_BYP   = 0;
   localparam int IN_NPO   = 1;
   localparam int IN_HOLD  = 2;
   localparam int IN_CONV  = 3;
   localparam int IN_TR    = 4;
   localparam int IN_FLEX  = 5;
   localparam int IN_RBM   = 6;
   localparam int IN_MFB   = 7;
   localparam int NUM_PIN  = 8;
   localparam int SYNC_STAGES = 3;
   localparam logic [NUM_CTL-1:0] CTL_MASK_RESET = 6'h00;

   //******************************************************************
   // Per-channel control word layout
   //******************************************************************
   localparam int WORD_W = 6;
   localparam int W_BYP  = 0;
   localparam int W_NPO  = 1;
   localparam int W_HOLD = 2;
   localparam int W_CLR  = 3;
   localparam int W_CONV = 4;
   localparam int W_TR   = 5;
   localparam int MEM_AW = CH_W + 1;

   //******************************************************************
   // Flexible control functions
   //******************************************************************
   localparam int FLEX_CTL_W = 3;
   localparam logic [FLEX_CTL_W-1:0] FCTL_NONE  = 3'h0;
   localparam logic [FLEX_CTL_W-1:0] FCTL_BYP   = 3'h1;
   localparam logic [FLEX_CTL_W-1:0] FCTL_NPO   = 3'h2;
   localparam logic [FLEX_CTL_W-1:0] FCTL_HOLD  = 3'h3;
   localparam logic [FLEX_CTL_W-1:0] FCTL_CONV  = 3'h4;
   localparam logic [FLEX_CTL_W-1:0] FCTL_TR    = 3'h5;
   localparam logic [FLEX_CTL_W-1:0] FCTL_CLR   = 3'h6;

   //******************************************************************
   // Flexible monitor conditions
   //******************************************************************
   localparam int FMON_W   = 4;
   localparam int FMON_A_HI = 7;
   localparam int FMON_A_LO = 4;
   localparam int FMON_B_HI = 3;
   localparam int FMON_B_LO = 0;
   localparam logic [FMON_W-1:0] FMON_OFF      = 4'h0;
   localparam logic [FMON_W-1:0] FMON_IDLE     = 4'h1;
   localparam logic [FMON_W-1:0] FMON_T2010    = 4'h2;
   localparam logic [FMON_W-1:0] FMON_T2100    = 4'h3;
   localparam logic [FMON_W-1:0] FMON_T2100_PR = 4'h4;
   localparam logic [FMON_W-1:0] FMON_DTALK    = 4'h5;
   localparam logic [FMON_W-1:0] FMON_NOSPEECH = 4'h6;

endpackage

/* chm_mem_if.sv */
/*
 * Interface between the serial port logic and its per-channel
 * control word store. Assumes one clock shared by both ends.
 */
`timescale 1ns/1ps

interface chm_mem_if #(
   parameter int ADDR_W = 6,
   parameter int DATA_W = 6
);
   logic              wr_en;
   logic [ADDR_W-1:0] wr_addr;
   logic [DATA_W-1:0] wr_data;
   logic              rd_en;
   logic [ADDR_W-1:0] rd_addr;
   logic [DATA_W-1:0] rd_data;

   // Port logic side
   modport ctl (output wr_en, wr_addr, wr_data, rd_en, rd_addr, input rd_data);
   // Store side
   modport mem (input wr_en, wr_addr, wr_data, rd_en, rd_addr, output rd_data);
endinterface

/* chm_state_mem.sv */
/*
 * Per-channel control word store: one write port, one read port whose
 * data come out of a register one clock after the read strobe.
 * Assumes the writer and reader never address the same word at once.
 */
`timescale 1ns/1ps

module chm_state_mem #(
   parameter int ADDR_W = 6,
   parameter int DATA_W = 6
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // Store port
   chm_mem_if.mem    bus
);

   logic [DATA_W-1:0] mem_array [0:(1<<ADDR_W)-1];
   logic [DATA_W-1:0] rd_data_reg;
   logic [DATA_W-1:0] rd_data_next;

   //******************************************************************
   // Storage
   //******************************************************************

   // Word array write
   always_ff @(posedge clk) begin
      if (bus.wr_en) begin
         mem_array[bus.wr_addr] <= bus.wr_data;
      end
   end

   // Read data next value
   always_comb begin
      rd_data_next = rd_data_reg;
      if (bus.rd_en) begin
         rd_data_next = mem_array[bus.rd_addr];
      end
   end

   // Read data register
   always_ff @(posedge clk) begin
      rd_data_reg <= rst ? '0 : rd_data_next;
   end

   assign bus.rd_data = rd_data_reg;

endmodule

/* chm_serial_port.sv */
/*
 * Per-channel serial control and monitor port. Generates the bit and
 * frame timing, samples six serial control streams, stores the
 * resulting per-channel control words double buffered, sends them back
 * on serial monitor outputs, and delays the multiframe marker.
 * Assumes detection flags from the canceller core on the same clock
 * and serial inputs arriving asynchronously on pins.
 */
`timescale 1ns/1ps

module chm_serial_port
   import chm_pkg::*;
#(
   parameter int MFB_DELAY_CYC = 16
) (
   // Clock and reset
   input  wire logic                CLK,
   input  wire logic                RESET,
   // Serial control inputs
   input  wire logic                BYPASS_CTL_IN,
   input  wire logic                NONLINEAR_PROC_OFF_IN,
   input  wire logic                COEF_HOLD_IN,
   input  wire logic                LAW_CONV_OFF_IN,
   input  wire logic                TRANSPARENT_CH_IN,
   input  wire logic                FLEX_CTL_IN,
   // Send highway markers
   input  wire logic                ROBBED_BIT_MARKER_IN,
   input  wire logic                TX_MULTIFRAME_BEGIN_IN,
   // Configuration
   input  wire logic [NUM_CTL-1:0]  CTL_MASK,
   input  wire logic [2:0]          FLEX_CTL_CONFIG,
   input  wire logic [7:0]          FLEX_MON_CONFIG,
   // Detection flags per channel
   input  wire logic [NUM_CH-1:0]   IDLE_DET,
   input  wire logic [NUM_CH-1:0]   TONE2010_DET,
   input  wire logic [NUM_CH-1:0]   TONE2100_DET,
   input  wire logic [NUM_CH-1:0]   TONE2100_REV_DET,
   input  wire logic [NUM_CH-1:0]   DOUBLE_TALK_DET,
   input  wire logic [NUM_CH-1:0]   NO_SPEECH_DET,
   // Frame timing
   output logic                     FRAME_SYNC_OUT,
   output logic [CH_W-1:0]          MON_CHANNEL,
   // Serial monitor outputs
   output logic                     BYPASS_MON_OUT,
   output logic                     NONLINEAR_PROC_OFF_MON_OUT,
   output logic                     COEF_HOLD_MON_OUT,
   output logic                     COEF_CLEAR_MON_OUT,
   output logic                     LAW_CONV_OFF_MON_OUT,
   output logic                     TRANSPARENT_CH_MON_OUT,
   output logic                     FLEX_MON_A_OUT,
   output logic                     FLEX_MON_B_OUT,
   // Delayed send highway markers
   output logic                     ROBBED_BIT_MARKER_OUT,
   output logic                     TX_MULTIFRAME_BEGIN_OUT
);

   //******************************************************************
   // Declarations
   //******************************************************************
   logic [NUM_PIN-1:0]       pin_vec;
   logic [NUM_PIN-1:0]       s1_reg;
   logic [NUM_PIN-1:0]       s2_reg;
   logic [NUM_PIN-1:0]       s3_reg;
   logic [NUM_PIN-1:0]       filt_reg;
   logic [NUM_PIN-1:0]       filt_next;

   logic [ACC_W-1:0]         acc_reg;
   logic [ACC_W-1:0]         acc_next;
   logic [ACC_W-1:0]         acc_sum;
   logic [CH_W-1:0]          bit_cnt_reg;
   logic [CH_W-1:0]          bit_cnt_next;
   logic                     bank_reg;
   logic                     bank_next;
   logic                     valid_reg;
   logic                     valid_next;
   logic [SYNC_CNT_W-1:0]    sync_cnt_reg;
   logic [SYNC_CNT_W-1:0]    sync_cnt_next;
   logic                     sync_out_reg;
   logic                     sync_out_next;
   logic                     bit_end;
   logic                     bit_mid;
   logic                     frame_end;

   logic [NUM_CTL-1:0]       ctl_act;
   logic                     flex_bit;
   logic [WORD_W-1:0]        word;

   logic                     load_reg;
   logic                     load_next;
   logic [CH_W-1:0]          rd_ch_reg;
   logic [CH_W-1:0]          rd_ch_next;
   logic [WORD_W-1:0]        mon_reg;
   logic [WORD_W-1:0]        mon_next;
   logic                     fmon_a_reg;
   logic                     fmon_a_next;
   logic                     fmon_b_reg;
   logic                     fmon_b_next;
   logic [CH_W-1:0]          mon_ch_reg;
   logic [CH_W-1:0]          mon_ch_next;

   logic [MFB_DELAY_CYC-1:0] rbm_dly_reg;
   logic [MFB_DELAY_CYC-1:0] rbm_dly_next;
   logic [MFB_DELAY_CYC-1:0] mfb_dly_reg;
   logic [MFB_DELAY_CYC-1:0] mfb_dly_next;

   chm_mem_if #(.ADDR_W(MEM_AW), .DATA_W(WORD_W)) mem_bus ();

   //******************************************************************
   // Pin synchronisers
   //******************************************************************

   // Pin vector in fixed index order
   assign pin_vec[IN_BYP]  = BYPASS_CTL_IN;
   assign pin_vec[IN_NPO]  = NONLINEAR_PROC_OFF_IN;
   assign pin_vec[IN_HOLD] = COEF_HOLD_IN;
   assign pin_vec[IN_CONV] = LAW_CONV_OFF_IN;
   assign pin_vec[IN_TR]   = TRANSPARENT_CH_IN;
   assign pin_vec[IN_FLEX] = FLEX_CTL_IN;
   assign pin_vec[IN_RBM]  = ROBBED_BIT_MARKER_IN;
   assign pin_vec[IN_MFB]  = TX_MULTIFRAME_BEGIN_IN;

   // Three stages per pin, level accepted when stages two and three agree
   generate
      for (genvar gi = 0; gi < NUM_PIN; gi++) begin : g_sync
         always_comb begin
            filt_next[gi] = (s2_reg[gi] == s3_reg[gi]) ? s3_reg[gi] : filt_reg[gi];
         end

         always_ff @(posedge CLK) begin
            if (RESET) begin
               s1_reg[gi]   <= 1'b0;
               s2_reg[gi]   <= 1'b0;
               s3_reg[gi]   <= 1'b0;
               filt_reg[gi] <= 1'b0;
            end else begin
               s1_reg[gi]   <= pin_vec[gi];
               s2_reg[gi]   <= s1_reg[gi];
               s3_reg[gi]   <= s2_reg[gi];
               filt_reg[gi] <= filt_next[gi];
            end
         end
      end
   endgenerate

   //******************************************************************
   // Bit and frame timing
   //******************************************************************

   // Fractional divider: 256 kbit/s from 20 MHz, exact 125 us frame
   always_comb begin
      acc_sum       = acc_reg + ACC_STEP;
      bit_end       = (acc_sum >= ACC_MOD);
      bit_mid       = (acc_reg < ACC_HALF) && (acc_sum >= ACC_HALF);
      frame_end     = bit_end && (bit_cnt_reg == CH_W'(NUM_CH - 1));
      acc_next      = bit_end ? (acc_sum - ACC_MOD) : acc_sum;
      bit_cnt_next  = bit_end ? (bit_cnt_reg + 5'h01) : bit_cnt_reg;
      bank_next     = frame_end ? ~bank_reg : bank_reg;
      valid_next    = valid_reg | frame_end;
      sync_cnt_next = sync_cnt_reg;
      if (frame_end) begin
         sync_cnt_next = SYNC_CNT_W'(SYNC_PULSE_CYC);
      end else if (sync_cnt_reg != '0) begin
         sync_cnt_next = sync_cnt_reg - 4'h1;
      end
      sync_out_next = (sync_cnt_next != '0);
   end

   // Timing registers
   always_ff @(posedge CLK) begin
      if (RESET) begin
         acc_reg      <= '0;
         bit_cnt_reg  <= '0;
         bank_reg     <= 1'b0;
         valid_reg    <= 1'b0;
         sync_cnt_reg <= '0;
         sync_out_reg <= 1'b0;
      end else begin
         acc_reg      <= acc_next;
         bit_cnt_reg  <= bit_cnt_next;
         bank_reg     <= bank_next;
         valid_reg    <= valid_next;
         sync_cnt_reg <= sync_cnt_next;
         sync_out_reg <= sync_out_next;
      end
   end

   //******************************************************************
   // Control word build and store write
   //******************************************************************

   // Masked, active-high control bits and resulting channel word
   always_comb begin
      ctl_act  = filt_reg[NUM_CTL-1:0] & ~CTL_MASK;
      flex_bit = ctl_act[IN_FLEX];
      word     = '0;
      word[W_BYP]  = ctl_act[IN_BYP] | ctl_act[IN_TR]
                   | (flex_bit && (FLEX_CTL_CONFIG == FCTL_BYP))
                   | (flex_bit && (FLEX_CTL_CONFIG == FCTL_TR));
      word[W_NPO]  = ctl_act[IN_NPO]
                   | (flex_bit && (FLEX_CTL_CONFIG == FCTL_NPO));
      word[W_HOLD] = ctl_act[IN_HOLD]
                   | (flex_bit && (FLEX_CTL_CONFIG == FCTL_HOLD));
      word[W_CONV] = ctl_act[IN_CONV] | ctl_act[IN_TR]
                   | (flex_bit && (FLEX_CTL_CONFIG == FCTL_CONV))
                   | (flex_bit && (FLEX_CTL_CONFIG == FCTL_TR));
      word[W_CLR]  = word[W_BYP]
                   | (flex_bit && (FLEX_CTL_CONFIG == FCTL_CLR));
      word[W_TR]   = word[W_BYP] & word[W_CONV];
   end

   // Sample mid-bit into the bank of the running frame
   assign mem_bus.wr_en   = bit_mid;
   assign mem_bus.wr_addr = {bank_reg, bit_cnt_reg};
   assign mem_bus.wr_data = word;

   // Read the next channel from the bank completed last frame
   assign mem_bus.rd_en   = bit_end;
   assign mem_bus.rd_addr = {~bank_next, bit_cnt_next};

   chm_state_mem #(
      .ADDR_W (MEM_AW),
      .DATA_W (WORD_W)
   ) u_state_mem (
      .clk (CLK),
      .rst (RESET),
      .bus (mem_bus.mem)
   );

   //******************************************************************
   // Monitor outputs
   //******************************************************************

   // Condition selected for a flexible monitor on one channel
   function automatic logic flex_cond(input logic [FMON_W-1:0] sel,
                                      input logic [CH_W-1:0]   ch);
      logic res;
      res = 1'b0;
      case (sel)
         FMON_IDLE:     res = IDLE_DET[ch];
         FMON_T2010:    res = TONE2010_DET[ch];
         FMON_T2100:    res = TONE2100_DET[ch] | TONE2100_REV_DET[ch];
         FMON_T2100_PR: res = TONE2100_REV_DET[ch];
         FMON_DTALK:    res = DOUBLE_TALK_DET[ch];
         FMON_NOSPEECH: res = NO_SPEECH_DET[ch];
         default:       res = 1'b0;
      endcase
      return res;
   endfunction

   // Load monitor bits one clock after the store answers
   always_comb begin
      load_next   = bit_end;
      rd_ch_next  = bit_end ? bit_cnt_next : rd_ch_reg;
      mon_next    = mon_reg;
      fmon_a_next = fmon_a_reg;
      fmon_b_next = fmon_b_reg;
      mon_ch_next = mon_ch_reg;
      if (load_reg) begin
         // Nothing stored yet before the first full frame
         mon_next    = valid_reg ? mem_bus.rd_data : '0;
         fmon_a_next = flex_cond(FLEX_MON_CONFIG[FMON_A_HI:FMON_A_LO], rd_ch_reg);
         fmon_b_next = flex_cond(FLEX_MON_CONFIG[FMON_B_HI:FMON_B_LO], rd_ch_reg);
         mon_ch_next = rd_ch_reg;
      end
   end

   // Monitor registers
   always_ff @(posedge CLK) begin
      if (RESET) begin
         load_reg   <= 1'b0;
         rd_ch_reg  <= '0;
         mon_reg    <= '0;
         fmon_a_reg <= 1'b0;
         fmon_b_reg <= 1'b0;
         mon_ch_reg <= '0;
      end else begin
         load_reg   <= load_next;
         rd_ch_reg  <= rd_ch_next;
         mon_reg    <= mon_next;
         fmon_a_reg <= fmon_a_next;
         fmon_b_reg <= fmon_b_next;
         mon_ch_reg <= mon_ch_next;
      end
   end

   //******************************************************************
   // Send highway marker delay
   //******************************************************************

   // Shift lines matching the send path delay
   always_comb begin
      rbm_dly_next = {rbm_dly_reg[MFB_DELAY_CYC-2:0], filt_reg[IN_RBM]};
      mfb_dly_next = {mfb_dly_reg[MFB_DELAY_CYC-2:0], filt_reg[IN_MFB]};
   end

   // Delay registers
   always_ff @(posedge CLK) begin
      if (RESET) begin
         rbm_dly_reg <= '0;
         mfb_dly_reg <= '0;
      end else begin
         rbm_dly_reg <= rbm_dly_next;
         mfb_dly_reg <= mfb_dly_next;
      end
   end

   //******************************************************************
   // Output drive
   //******************************************************************
   assign FRAME_SYNC_OUT             = sync_out_reg;
   assign MON_CHANNEL                = mon_ch_reg;
   assign BYPASS_MON_OUT             = mon_reg[W_BYP];
   assign NONLINEAR_PROC_OFF_MON_OUT = mon_reg[W_NPO];
   assign COEF_HOLD_MON_OUT          = mon_reg[W_HOLD];
   assign COEF_CLEAR_MON_OUT         = mon_reg[W_CLR];
   assign LAW_CONV_OFF_MON_OUT       = mon_reg[W_CONV];
   assign TRANSPARENT_CH_MON_OUT     = mon_reg[W_TR];
   assign FLEX_MON_A_OUT             = fmon_a_reg;
   assign FLEX_MON_B_OUT             = fmon_b_reg;
   assign ROBBED_BIT_MARKER_OUT      = rbm_dly_reg[MFB_DELAY_CYC-1];
   assign TX_MULTIFRAME_BEGIN_OUT    = mfb_dly_reg[MFB_DELAY_CYC-1];

endmodule

/* chm_serial_port_props.sv */
/* Assertions on the serial port's top pins, bound after the module.
   Assumes one clock and a synchronous, active high reset. */
`timescale 1ns/1ps
module chm_serial_port_props
   import chm_pkg::*;
#(parameter int MFB_DELAY_CYC = 16) (
   // Clock and reset
   input wire logic            CLK,
   input wire logic            RESET,
   // Watched pins
   input wire logic            FRAME_SYNC_OUT,
   input wire logic [CH_W-1:0] MON_CHANNEL,
   input wire logic            BYPASS_MON_OUT,
   input wire logic            COEF_CLEAR_MON_OUT,
   input wire logic            LAW_CONV_OFF_MON_OUT,
   input wire logic            TRANSPARENT_CH_MON_OUT,
   input wire logic            FLEX_MON_A_OUT,
   input wire logic            TX_MULTIFRAME_BEGIN_IN,
   input wire logic            TX_MULTIFRAME_BEGIN_OUT,
   input wire logic            ROBBED_BIT_MARKER_IN,
   input wire logic            ROBBED_BIT_MARKER_OUT
);
   logic [11:0] per_reg, per_next, slot_reg, slot_next;
   logic [4:0]  ch_reg;
   logic [1:0]  rises_reg, rises_next;
   logic        fs_reg, rise, chg;
   // Cycles since sync rise and since channel step
   always_comb begin
      rise = FRAME_SYNC_OUT && !fs_reg;
      chg = MON_CHANNEL != ch_reg;
      per_next = rise ? 12'h001 : per_reg + 12'h001;
      slot_next = chg ? 12'h001 : slot_reg + 12'h001;
      rises_next = (rise && rises_reg != 2'h3) ? rises_reg + 2'h1 : rises_reg;
   end
   // Helper registers, cleared by reset
   always_ff @(posedge CLK) begin
      if (RESET) begin
         {fs_reg, ch_reg, per_reg, slot_reg, rises_reg} <= '0;
      end else begin
         {fs_reg, ch_reg, per_reg, slot_reg, rises_reg} <=
            {FRAME_SYNC_OUT, MON_CHANNEL, per_next, slot_next, rises_next};
      end
   end
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RESET);
   AST_SYNC_WIDTH: assert property ($rose(FRAME_SYNC_OUT) |->
      FRAME_SYNC_OUT[*8] ##1 FRAME_SYNC_OUT ##1 !FRAME_SYNC_OUT) else $error("sync width");
   AST_SYNC_PERIOD: assert property (rise && rises_reg != 2'h0 |-> per_reg == 12'h9c4)
      else $error("sync period");
   AST_CH_ZERO: assert property ($rose(FRAME_SYNC_OUT) |=> MON_CHANNEL == 5'h00)
      else $error("channel 0 not after sync");
   AST_CH_ORDER: assert property (chg |-> MON_CHANNEL == ch_reg + 5'h01)
      else $error("channel order");
   AST_SLOT_LEN: assert property (chg && rises_reg[1] |-> slot_reg inside {12'h04e, 12'h04f})
      else $error("bit period length");
   AST_TR_MON: assert property (TRANSPARENT_CH_MON_OUT == (BYPASS_MON_OUT && LAW_CONV_OFF_MON_OUT))
      else $error("transparent monitor");
   AST_CLR_MON: assert property (BYPASS_MON_OUT |-> COEF_CLEAR_MON_OUT)
      else $error("bypass without clear");
   AST_MON_HOLD: assert property (!chg |-> $stable(BYPASS_MON_OUT) && $stable(FLEX_MON_A_OUT))
      else $error("monitor bit changed inside slot");
   AST_MFB_DELAY: assert property ((rises_reg != 2'h0 || per_reg > 12'h020) |->
      TX_MULTIFRAME_BEGIN_OUT == $past(TX_MULTIFRAME_BEGIN_IN, MFB_DELAY_CYC + 4))
      else $error("multiframe marker delay");
   AST_RBM_DELAY: assert property ((rises_reg != 2'h0 || per_reg > 12'h020) |->
      ROBBED_BIT_MARKER_OUT == $past(ROBBED_BIT_MARKER_IN, MFB_DELAY_CYC + 4))
      else $error("robbed bit marker delay");
   COV_SYNC: cover property (rise && rises_reg[1]);
   COV_TRANSP: cover property (TRANSPARENT_CH_MON_OUT);
   COV_MFB: cover property (TX_MULTIFRAME_BEGIN_OUT);
endmodule
bind chm_serial_port chm_serial_port_props #(.MFB_DELAY_CYC(MFB_DELAY_CYC)) chm_props_inst (
   .CLK(CLK), .RESET(RESET), .FRAME_SYNC_OUT(FRAME_SYNC_OUT), .MON_CHANNEL(MON_CHANNEL),
   .BYPASS_MON_OUT(BYPASS_MON_OUT), .COEF_CLEAR_MON_OUT(COEF_CLEAR_MON_OUT),
   .LAW_CONV_OFF_MON_OUT(LAW_CONV_OFF_MON_OUT), .FLEX_MON_A_OUT(FLEX_MON_A_OUT),
   .TRANSPARENT_CH_MON_OUT(TRANSPARENT_CH_MON_OUT),
   .TX_MULTIFRAME_BEGIN_IN(TX_MULTIFRAME_BEGIN_IN),
   .TX_MULTIFRAME_BEGIN_OUT(TX_MULTIFRAME_BEGIN_OUT),
   .ROBBED_BIT_MARKER_IN(ROBBED_BIT_MARKER_IN), .ROBBED_BIT_MARKER_OUT(ROBBED_BIT_MARKER_OUT));

/* chm_ctl_partner.sv */
/* Outside control logic: drives the six serial control streams and
   the send markers. Assumes the port's frame sync marks channel 0. */
`timescale 1ns/1ps
module chm_ctl_partner
   import chm_pkg::*;
(
   // Clock, reset, frame timing
   input  wire logic                           clk,
   input  wire logic                           rst,
   input  wire logic                           frame_sync,
   // One row of channel bits per control input
   input  wire logic [NUM_CTL-1:0][NUM_CH-1:0] pattern,
   // Serial streams and markers
   output logic      [NUM_CTL-1:0]             ctl_out,
   output logic                                rbm_out,
   output logic                                mfb_out
);
   logic        fs_d = 1'b0;
   logic        run = 1'b0;
   logic [11:0] cyc = 12'h000;
   logic [4:0]  ch;
   // Cycle count in frame, restarted at each sync rise
   always @(posedge clk) begin
      fs_d <= frame_sync;
      if (rst) begin
         run <= 1'b0;
      end else if (frame_sync && !fs_d) begin
         run <= 1'b1;
         cyc <= 12'h000;
      end else if (cyc != 12'h9c3) begin
         cyc <= cyc + 12'h001;
      end
   end
   // One bit per channel slot
   assign ch = 5'((32'(cyc) * 32'h20) / 32'h9c4);
   always_comb begin
      for (int i = 0; i < NUM_CTL; i++) begin
         ctl_out[i] = run && pattern[i][ch];
      end
      rbm_out = run && (ch == 5'h05);
      mfb_out = run && (cyc < 12'h004);
   end
endmodule

/* chm_tb.sv */
/* Self-checking bench for the serial port with the control partner.
   Assumes a 20 MHz clock and the package constants. */
`timescale 1ns/1ps
module testbench
   import chm_pkg::*;
();
   logic                           clk = 1'b0;
   logic                           rst = 1'b1;
   logic [NUM_CTL-1:0][NUM_CH-1:0] pat = '0;
   logic [NUM_CTL-1:0]             mask = '0;
   logic [2:0]                     fcfg = 3'h0;
   logic [7:0]                     mcfg = 8'h00;
   logic [NUM_CH-1:0]              det [6] = '{32'h0000ffff, 32'h00ff00ff,
      32'h0f0f0f0f, 32'h3c3c3c3c, 32'h33333333, 32'h55555555};
   wire  [NUM_CTL-1:0]             ctl;
   wire  [7:0]                     mon;
   wire  [4:0]                     mch;
   wire                            fs, rbm, mfb;
   int                             n_mismatch = 0;
   int                             n_compared = 0;
   chm_ctl_partner chm_ctl_partner_inst (.clk(clk), .rst(rst), .frame_sync(fs),
      .pattern(pat), .ctl_out(ctl), .rbm_out(rbm), .mfb_out(mfb));
   chm_serial_port #(.MFB_DELAY_CYC(16)) chm_serial_port_inst (.CLK(clk), .RESET(rst),
      .BYPASS_CTL_IN(ctl[0]), .NONLINEAR_PROC_OFF_IN(ctl[1]), .COEF_HOLD_IN(ctl[2]),
      .LAW_CONV_OFF_IN(ctl[3]), .TRANSPARENT_CH_IN(ctl[4]), .FLEX_CTL_IN(ctl[5]),
      .ROBBED_BIT_MARKER_IN(rbm), .TX_MULTIFRAME_BEGIN_IN(mfb), .CTL_MASK(mask),
      .FLEX_CTL_CONFIG(fcfg), .FLEX_MON_CONFIG(mcfg), .IDLE_DET(det[0]),
      .TONE2010_DET(det[1]), .TONE2100_DET(det[2]), .TONE2100_REV_DET(det[3]),
      .DOUBLE_TALK_DET(det[4]), .NO_SPEECH_DET(det[5]), .FRAME_SYNC_OUT(fs),
      .MON_CHANNEL(mch), .BYPASS_MON_OUT(mon[0]), .NONLINEAR_PROC_OFF_MON_OUT(mon[1]),
      .COEF_HOLD_MON_OUT(mon[2]), .COEF_CLEAR_MON_OUT(mon[3]),
      .LAW_CONV_OFF_MON_OUT(mon[4]), .TRANSPARENT_CH_MON_OUT(mon[5]),
      .FLEX_MON_A_OUT(mon[6]), .FLEX_MON_B_OUT(mon[7]), .ROBBED_BIT_MARKER_OUT(),
      .TX_MULTIFRAME_BEGIN_OUT());
   // Clock
   initial forever #25 clk = ~clk;
   // Compare and count
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Flexible monitor condition for one channel
   function automatic logic fsel(input logic [3:0] s, input logic [4:0] c);
      // Code 3 is the tone with or without phase reversal
      return (s == 4'h3) ? (det[2][c] | det[3][c]) :
         (s >= 4'h1 && s <= 4'h6) ? det[s - 4'h1][c] : 1'b0;
   endfunction
   // Expected monitor bits for one channel
   function automatic logic [7:0] expect_mon(input logic [4:0] c);
      logic [5:0] m;
      logic       fx, byp, cnv;
      for (int i = 0; i < NUM_CTL; i++) m[i] = pat[i][c] && !mask[i];
      fx = m[IN_FLEX];
      byp = m[IN_BYP] | m[IN_TR] | (fx && (fcfg == FCTL_BYP || fcfg == FCTL_TR));
      cnv = m[IN_CONV] | m[IN_TR] | (fx && (fcfg == FCTL_CONV || fcfg == FCTL_TR));
      return {fsel(mcfg[3:0], c), fsel(mcfg[7:4], c), byp & cnv, cnv,
         byp | (fx && fcfg == FCTL_CLR), m[IN_HOLD] | (fx && fcfg == FCTL_HOLD),
         m[IN_NPO] | (fx && fcfg == FCTL_NPO), byp};
   endfunction
   // Let a whole frame be sampled, then check the next one slot by slot
   task automatic check_frame();
      repeat (2) @(posedge fs);
      for (int c = 0; c < NUM_CH; c++) begin
         repeat ((c == 0) ? 40 : 78) @(negedge clk);
         check({3'h0, mch}, 8'(c));
         check(mon, expect_mon(5'(c)));
      end
      @(posedge clk);
   endtask
   // Each input on its own channel mix
   task automatic sc_direct();
      pat <= {32'h12345678, 32'hffff0000, 32'hff00ff00, 32'hf0f0f0f0,
         32'hcccccccc, 32'haaaaaaaa};
      mcfg <= 8'h12;
      check_frame();
   endtask
   // Every flex function and monitor code, one mask bit each
   task automatic sc_flex();
      for (int f = 0; f < 8; f++) begin
         fcfg <= 3'(f);
         mask <= 6'(1 << (f % 5));
         mcfg <= {4'(f), 4'(7 - f)};
         for (int j = 0; j < 6; j++) det[j] <= {det[j][30:0], det[j][31]};
         check_frame();
      end
   endtask
   // All inputs masked
   task automatic sc_mask_all();
      mask <= 6'h3f;
      mcfg <= 8'h66;
      check_frame();
   endtask
   // Report counts and end the run
   task automatic give_verdict();
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      repeat (100) @(posedge clk);
      check(mon, 8'h00);
      sc_direct();
      sc_flex();
      sc_mask_all();
      give_verdict();
   end
   // Watchdog
   initial begin
      #(70000 * 50);
      n_mismatch++;
      give_verdict();
   end
endmodule
